// ===== request_accept_pkg.sv
// Shared constants, register map and carrier types of the request status and acceptance block.
package request_accept_pkg;

    // Register port geometry.
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;

    // Register offsets, one word each.
    localparam logic [3:0] OFF_STATUS_A = 4'h0;
    localparam logic [3:0] OFF_STATUS_B = 4'h1;
    localparam logic [3:0] OFF_PRIORITY = 4'h2;
    localparam logic [3:0] OFF_STATUS_WORD = 4'h3;
    localparam logic [3:0] OFF_SAVED_STATUS = 4'h4;
    localparam logic [3:0] OFF_SAVED_PC = 4'h5;
    localparam logic [3:0] OFF_VECTOR_BASE = 4'h6;
    localparam logic [3:0] OFF_EVENT_CODE = 4'h7;
    localparam logic [3:0] OFF_EVENT_CODE_ALT = 4'h8;
    localparam logic [3:0] OFF_EVT_STATUS = 4'h9;
    localparam logic [3:0] OFF_EVT_ENABLE = 4'ha;
    localparam logic [3:0] OFF_EVT_CLEAR = 4'hb;

    // Reset values of the software-visible registers.
    localparam logic [7:0] RST_REQUEST_STATUS = 8'h00;
    localparam logic [15:0] RST_PRIORITY = 16'h0000;
    localparam logic [31:0] RST_STATUS_WORD = 32'h700000f0;
    localparam logic [31:0] RST_WORD = 32'h00000000;
    localparam logic [1:0] RST_EVT = 2'h0;

    // Field positions inside the status word.
    localparam int SW_PRIV_BIT = 30;
    localparam int SW_BANK_BIT = 29;
    localparam int SW_HOLD_BIT = 28;
    localparam int SW_MASK_LSB = 4;
    localparam int LEVEL_W = 4;

    // Source numbering: index 0 is the highest fixed default order.
    localparam int NUM_SOURCES = 13;
    localparam int SRC_IDX_W = 4;
    localparam int UNIT_SPAN = 4;
    localparam logic [2:0] STATUS_B_RESERVED = 3'h0;

    // Handler offset and event code layout.
    localparam logic [31:0] HANDLER_OFFSET = 32'h00000600;
    localparam logic [11:0] EVENT_CODE_BASE = 12'h400;
    localparam int EVENT_CODE_W = 12;

    // Block event bits.
    localparam int EVT_TAKEN_BIT = 0;
    localparam int EVT_NOTIFY_BIT = 1;

    // Redirect handed to the instruction fetch when an interrupt is taken.
    typedef struct packed {
        logic valid;
        logic [31:0] target;
    } branch_t;

endpackage

// ===== request_accept.sv
// Request status registers, priority selection and interrupt acceptance sequencing.
`timescale 1ns/1ps

// Overview of operation
// RULE_01 - Status A: infrared and DMA end flags
// RULE_02 - Status registers clear on reset only; the code also clears each flag one edge after its request line drops
// RULE_03 - Status B: conversion end, FIFO serial flags
// RULE_04 - Status B bits 7..5 read zero
// RULE_05 - Highest programmed level wins, others stay pending
// RULE_06 - Ties resolved by fixed default order
// RULE_07 - Accept only when level exceeds mask
// RULE_08 - Acceptance drives request-out pin low
// RULE_09 - Pin low until cleared or masked
// RULE_10 - Synchronous notify, take at instruction boundary
// RULE_11 - Load source code into both event registers
// RULE_12 - Save status word and program counter
// RULE_13 - Set hold, privilege and bank flags
// RULE_14 - Branch to vector base plus offset
// RULE_15 - Mask level unchanged by acceptance
// RULE_16 - Handler clears flag, reads back, waits
// RULE_17 - Nesting after hold cleared and mask raised
// RULE_18 - Hold flag defers interrupt taking
// RULE_19 - Status bits live, writes ignored
module request_accept
    import request_accept_pkg::*;
#(
    parameter int SOURCES = NUM_SOURCES
) (
    input wire logic ref_clk, // Peripheral clock, 25 MHz.
    input wire logic nrst, // Asynchronous active-low reset.
    input wire logic [ADDR_W-1:0] reg_addr, // Register address.
    input wire logic [DATA_W-1:0] reg_wdata, // Register write data.
    input wire logic reg_write, // Write strobe, one cycle.
    input wire logic reg_read, // Read strobe, one cycle.
    output logic [DATA_W-1:0] reg_rdata, // Read data, valid the cycle after the strobe.
    input wire logic [3:0] dma_end_req, // DMA channel 3..0 end requests.
    input wire logic [3:0] infrared_req, // Infrared transmit, break, receive, error.
    input wire logic [3:0] fifo_serial_req, // FIFO serial transmit, break, receive, error.
    input wire logic conversion_end_req, // A/D conversion end request.
    input wire logic instr_boundary, // CPU sits between two instructions.
    input wire logic [31:0] cpu_pc, // Program counter of the next instruction.
    output logic cpu_notify, // Accepted request signalled to the CPU.
    output branch_t cpu_branch, // One-cycle redirect to the handler.
    output logic request_out_pin_n, // External request-out pin, low while accepted.
    output logic irq // Level interrupt from the block event bits.
);

    // Reset synchroniser; the first stage is read only by the second.
    logic rst_meta_n; // First synchroniser stage.
    logic rst_n; // Released reset used by the design.

    // Sampled request lines as seen through the status registers.
    logic [7:0] peripheral_request_status_a; // Infrared and DMA end flags.
    logic [4:0] status_b_live; // Conversion end and FIFO serial flags.
    logic [7:0] peripheral_request_status_b; // Full register view with reserved bits.
    logic [SOURCES-1:0] src_pending; // Flattened pending vector in default order.

    // Software programmed state.
    logic [15:0] priority_level_registers; // Per-unit levels: DMA, infrared, FIFO serial, converter.
    logic [31:0] cpu_status_word; // Status word with mask and flags.
    logic [31:0] saved_status_word; // Copy of the status word at acceptance.
    logic [31:0] saved_program_counter; // Copy of the program counter at acceptance.
    logic [31:0] vector_base; // Base of the handler vector.
    logic [EVENT_CODE_W-1:0] event_code_register; // Code of the last accepted source.
    logic [EVENT_CODE_W-1:0] event_code_register_alt; // Second copy of the code.
    logic [1:0] evt_status; // Sticky block events.
    logic [1:0] evt_enable; // Enables for the block events.

    // Selection results.
    logic [LEVEL_W-1:0] src_level [SOURCES]; // Programmed level of each source.
    logic sel_valid; // Some source has a nonzero level pending.
    logic [LEVEL_W-1:0] sel_level; // Level of the winner.
    logic [SRC_IDX_W-1:0] sel_index; // Index of the winner.

    // Decode and sequencing wires.
    wire [LEVEL_W-1:0] mask_level = cpu_status_word[SW_MASK_LSB +: LEVEL_W];
    wire exception_hold_flag = cpu_status_word[SW_HOLD_BIT];
    wire accept_now = sel_valid && (sel_level > mask_level);
    wire take_now = cpu_notify && accept_now && instr_boundary && !exception_hold_flag;
    wire notify_rise = accept_now && !cpu_notify;
    wire [EVENT_CODE_W-1:0] sel_code = EVENT_CODE_BASE + {3'h0, sel_index, 5'h00};
    wire [31:0] handler_target = vector_base + HANDLER_OFFSET;
    wire wr_priority = reg_write && (reg_addr == OFF_PRIORITY);
    wire wr_status_word = reg_write && (reg_addr == OFF_STATUS_WORD);
    wire wr_vector_base = reg_write && (reg_addr == OFF_VECTOR_BASE);
    wire wr_evt_enable = reg_write && (reg_addr == OFF_EVT_ENABLE);
    wire wr_evt_clear = reg_write && (reg_addr == OFF_EVT_CLEAR);
    wire [1:0] evt_set = {notify_rise, take_now};
    wire [1:0] evt_clear = wr_evt_clear ? reg_wdata[1:0] : 2'h0;
    logic [DATA_W-1:0] next_rdata; // Read mux output, registered into reg_rdata.

    // The reset is released through two flops so all logic leaves reset on one edge.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_n <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n <= rst_meta_n;
        end
    end

    // The request lines come from on-chip peripherals on this clock, so they are sampled
    // once without a synchroniser; the flag follows its line and is never written.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            peripheral_request_status_a <= RST_REQUEST_STATUS; // RULE_02
            status_b_live <= RST_REQUEST_STATUS[4:0]; // RULE_02
        end else begin
            peripheral_request_status_a <= {infrared_req, dma_end_req}; // RULE_01 RULE_19
            status_b_live <= {conversion_end_req, fifo_serial_req}; // RULE_03 RULE_19
        end
    end

    // The reserved top bits are hard zero whatever software wrote.
    assign peripheral_request_status_b = {STATUS_B_RESERVED, status_b_live}; // RULE_04

    // Flatten in default order: DMA 0..3, infrared error, receive, break, transmit,
    // FIFO serial error, receive, break, transmit, then the converter.
    assign src_pending = {status_b_live, peripheral_request_status_a};

    // Each group of four sources shares one level field of the priority register.
    generate
        for (genvar g = 0; g < SOURCES; g++) begin : g_level
            localparam int UNIT = g / UNIT_SPAN;
            assign src_level[g] = priority_level_registers[UNIT*LEVEL_W +: LEVEL_W]; // RULE_05
        end
    endgenerate

    // Walk the sources from the highest default order down. A later source replaces the
    // winner only with a strictly higher level, so ties keep the earlier one. Losers are
    // not touched: their lines stay asserted and they remain pending.
    always_comb begin
        sel_valid = 1'b0;
        sel_level = '0;
        sel_index = '0;
        for (int i = 0; i < SOURCES; i++) begin
            if (src_pending[i] && (src_level[i] != '0)) begin
                if (!sel_valid || (src_level[i] > sel_level)) begin // RULE_05 RULE_06
                    sel_valid = 1'b1;
                    sel_level = src_level[i];
                    sel_index = SRC_IDX_W'(i);
                end
            end
        end
    end

    // Notify the CPU and drive the pin on the clock edge after the comparison holds. The
    // pin ignores the hold flag on purpose, so an external agent sees the request even
    // while the CPU is busy in a handler; it rises once the source drops or gets masked.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cpu_notify <= 1'b0;
            request_out_pin_n <= 1'b1;
        end else begin
            cpu_notify <= accept_now; // RULE_07 RULE_10
            request_out_pin_n <= !accept_now; // RULE_08 RULE_09
        end
    end

    // Programmable priority levels and vector base.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            priority_level_registers <= RST_PRIORITY;
            vector_base <= RST_WORD;
        end else begin
            if (wr_priority) begin
                priority_level_registers <= reg_wdata[15:0];
            end
            if (wr_vector_base) begin
                vector_base <= reg_wdata;
            end
        end
    end

    // Status word. Taking an interrupt wins over a software write in the same cycle,
    // because losing the hold flag there would let a second request in behind the first.
    // Only the hold, privilege and bank flags change; the mask is left alone, so the
    // handler must raise it itself before clearing the hold flag to nest.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cpu_status_word <= RST_STATUS_WORD;
        end else if (take_now) begin
            cpu_status_word[SW_HOLD_BIT] <= 1'b1; // RULE_13
            cpu_status_word[SW_PRIV_BIT] <= 1'b1; // RULE_13
            cpu_status_word[SW_BANK_BIT] <= 1'b1; // RULE_13 RULE_15
        end else if (wr_status_word) begin
            cpu_status_word <= reg_wdata; // RULE_17
        end
    end

    // Context saved at the moment of taking; software may reload both for nesting.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            saved_status_word <= RST_WORD;
            saved_program_counter <= RST_WORD;
        end else if (take_now) begin
            saved_status_word <= cpu_status_word; // RULE_12
            saved_program_counter <= cpu_pc; // RULE_12
        end else if (reg_write && (reg_addr == OFF_SAVED_STATUS)) begin
            saved_status_word <= reg_wdata;
        end else if (reg_write && (reg_addr == OFF_SAVED_PC)) begin
            saved_program_counter <= reg_wdata;
        end
    end

    // Both event code registers receive the same code, spaced so it is a branch offset.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            event_code_register <= '0;
            event_code_register_alt <= '0;
        end else if (take_now) begin
            event_code_register <= sel_code; // RULE_11
            event_code_register_alt <= sel_code; // RULE_11
        end
    end

    // Redirect pulse for one cycle; the fetch unit treats it as an immediate jump with
    // no delay slot. Taking waits for a boundary and for the hold flag to be clear.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cpu_branch <= '0;
        end else begin
            cpu_branch.valid <= take_now; // RULE_10 RULE_18
            cpu_branch.target <= take_now ? handler_target : cpu_branch.target; // RULE_14
        end
    end

    // Sticky block events: a set in the same cycle as its clear survives.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            evt_status <= RST_EVT;
            evt_enable <= RST_EVT;
        end else begin
            evt_status <= (evt_status & ~evt_clear) | evt_set;
            if (wr_evt_enable) begin
                evt_enable <= reg_wdata[1:0];
            end
        end
    end

    // Interrupt output stays high while any enabled event is pending.
    assign irq = |(evt_status & evt_enable);

    // Read mux. The status registers are the handler's read-back point after it clears
    // a source: the flag follows the line one cycle late, which is why the handler must
    // still wait the decision interval before dropping the hold flag.
    always_comb begin
        next_rdata = '0;
        case (reg_addr)
            OFF_STATUS_A: begin
                next_rdata[7:0] = peripheral_request_status_a; // RULE_16
            end
            OFF_STATUS_B: begin
                next_rdata[7:0] = peripheral_request_status_b; // RULE_04
            end
            OFF_PRIORITY: begin
                next_rdata[15:0] = priority_level_registers;
            end
            OFF_STATUS_WORD: begin
                next_rdata = cpu_status_word;
            end
            OFF_SAVED_STATUS: begin
                next_rdata = saved_status_word;
            end
            OFF_SAVED_PC: begin
                next_rdata = saved_program_counter;
            end
            OFF_VECTOR_BASE: begin
                next_rdata = vector_base;
            end
            OFF_EVENT_CODE: begin
                next_rdata[EVENT_CODE_W-1:0] = event_code_register;
            end
            OFF_EVENT_CODE_ALT: begin
                next_rdata[EVENT_CODE_W-1:0] = event_code_register_alt;
            end
            OFF_EVT_STATUS: begin
                next_rdata[1:0] = evt_status;
            end
            OFF_EVT_ENABLE: begin
                next_rdata[1:0] = evt_enable;
            end
            default: begin
                next_rdata = '0; // Unmapped and write-only offsets read zero.
            end
        endcase
    end

    // Read data is registered and stands only in the cycle after the strobe.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else if (reg_read) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= '0;
        end
    end

endmodule

// ===== request_accept_sva.sv
// Port-level concurrent checks for the request status and acceptance block.
`timescale 1ns/1ps
module request_accept_sva
    import request_accept_pkg::*;
#(
    parameter int SOURCES = NUM_SOURCES
) (
    input wire logic ref_clk, // Peripheral clock.
    input wire logic nrst, // Active-low reset.
    input wire logic [ADDR_W-1:0] reg_addr, // Register address.
    input wire logic reg_read, // Read strobe.
    input wire logic [DATA_W-1:0] reg_rdata, // Read data.
    input wire logic [3:0] dma_end_req, // DMA end lines.
    input wire logic [3:0] infrared_req, // Infrared lines.
    input wire logic [3:0] fifo_serial_req, // FIFO serial lines.
    input wire logic conversion_end_req, // Converter line.
    input wire logic instr_boundary, // CPU between instructions.
    input wire logic cpu_notify, // Notify to the CPU.
    input wire branch_t cpu_branch, // Handler redirect.
    input wire logic request_out_pin_n // Request-out pin.
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    // A read strobe at one address; its answer stands one edge later.
    sequence rd_at(logic [3:0] a);
        reg_read && reg_addr == a;
    endsequence

    // Status lags the line by one edge and the read by one more, hence depth two.
    a_rdata_quiet: assert property (!$past(reg_read) |-> reg_rdata == '0)
        else $error("read data not zero outside a read answer");
    a_status_a_live: assert property (rd_at(OFF_STATUS_A) |=>
        reg_rdata == {24'h0, $past(infrared_req, 2), $past(dma_end_req, 2)})
        else $error("status a does not follow the request lines");
    a_status_b_live: assert property (rd_at(OFF_STATUS_B) |=>
        reg_rdata[4:0] == {$past(conversion_end_req, 2), $past(fifo_serial_req, 2)})
        else $error("status b does not follow the request lines");
    a_reserved_zero: assert property (rd_at(OFF_STATUS_B) |=> reg_rdata[31:5] == '0)
        else $error("status b reserved bits not zero");
    a_pin_mirror: assert property (!request_out_pin_n |->
        cpu_notify && $past(|{dma_end_req, infrared_req, fifo_serial_req, conversion_end_req}, 2))
        else $error("request-out pin low without a pending request");
    a_notify_cause: assert property (cpu_notify |->
        $past(|{dma_end_req, infrared_req, fifo_serial_req, conversion_end_req}, 2))
        else $error("notify without a pending request");
    a_take_cause: assert property ($rose(cpu_branch.valid) |->
        $past(cpu_notify) && $past(instr_boundary))
        else $error("redirect without notify at a boundary");
    a_take_single: assert property (cpu_branch.valid |=> !cpu_branch.valid)
        else $error("redirect longer than one cycle");
endmodule

bind request_accept request_accept_sva #(.SOURCES(SOURCES)) request_accept_sva_i (
    .ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .dma_end_req(dma_end_req), .infrared_req(infrared_req), .fifo_serial_req(fifo_serial_req),
    .conversion_end_req(conversion_end_req), .instr_boundary(instr_boundary), .cpu_notify(cpu_notify),
    .cpu_branch(cpu_branch), .request_out_pin_n(request_out_pin_n));

// ===== cpu_model.sv
// Behavioural CPU core that offers instruction boundaries and follows handler redirects.
`timescale 1ns/1ps
module cpu_model
    import request_accept_pkg::*;
(
    input wire logic ref_clk, // Peripheral clock.
    input wire logic slow, // High while executing four-cycle instructions.
    input wire branch_t cpu_branch, // Redirect from the block.
    output logic instr_boundary, // Between two instructions.
    output logic [31:0] cpu_pc, // Program counter of the next instruction.
    output logic [7:0] takes // Count of redirects seen.
);
    logic [1:0] phase; // Position inside a slow instruction.

    // Start at an arbitrary program address, between instructions.
    initial begin
        instr_boundary = 1'b1;
        cpu_pc = 32'h00002468;
        takes = 8'h00;
        phase = 2'h0;
    end

    // Slow instructions offer a boundary only every fourth cycle, so a take must wait for it.
    always @(posedge ref_clk) begin
        phase <= phase + 2'h1;
        instr_boundary <= !slow || phase == 2'h3;
        if (cpu_branch.valid) begin
            cpu_pc <= cpu_branch.target;
            takes <= takes + 8'h01;
        end
    end
endmodule

// ===== tb.sv
// Self-checking bench for the request status and acceptance block.
`timescale 1ns/1ps
module tb
    import request_accept_pkg::*;
;
    logic ref_clk, nrst, reg_write, reg_read, conversion_end_req, slow; // Bench-driven controls.
    logic [ADDR_W-1:0] reg_addr; // Register address.
    logic [DATA_W-1:0] reg_wdata, reg_rdata; // Register data.
    logic [3:0] dma_end_req, infrared_req, fifo_serial_req; // Source request lines.
    logic instr_boundary, cpu_notify, request_out_pin_n, irq; // Block and CPU status.
    logic [31:0] cpu_pc; // Program counter from the CPU model.
    logic [7:0] takes; // Redirects seen by the CPU model.
    branch_t cpu_branch; // Handler redirect.
    int failures = 0; // Mismatches.
    int num_checks = 0; // Comparisons.
    int cycles = 0; // Clock cycles since start.

    request_accept request_accept_i (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .dma_end_req(dma_end_req), .infrared_req(infrared_req), .fifo_serial_req(fifo_serial_req),
        .conversion_end_req(conversion_end_req), .instr_boundary(instr_boundary), .cpu_pc(cpu_pc),
        .cpu_notify(cpu_notify), .cpu_branch(cpu_branch), .request_out_pin_n(request_out_pin_n), .irq(irq));
    cpu_model cpu_model_i (.ref_clk(ref_clk), .slow(slow), .cpu_branch(cpu_branch),
        .instr_boundary(instr_boundary), .cpu_pc(cpu_pc), .takes(takes));

    // Free-running 25 MHz clock.
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Each bus task ends one edge after dropping its strobe, so calls never collide.
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge ref_clk);
        reg_write <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge ref_clk);
        reg_read <= 1'b0;
        @(negedge ref_clk);
        chk(reg_rdata, exp);
        @(posedge ref_clk);
    endtask

    // Bounded wait for the one-cycle redirect, then check where it points.
    task automatic wait_take(input logic [31:0] target);
        int n;
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (cpu_branch.valid !== 1'b1 && n < 40);
        chk({31'h0, cpu_branch.valid}, 32'h1);
        chk(cpu_branch.target, target);
        @(posedge ref_clk);
    endtask

    task automatic results;
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // A hang is cut off well past the hundred-odd cycles the tests need.
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            results();
        end
    end

    initial begin
        nrst = 1'b0;
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        dma_end_req = 4'h0;
        infrared_req = 4'h0;
        fifo_serial_req = 4'h0;
        conversion_end_req = 1'b0;
        slow = 1'b0;
        repeat (16) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        // Reset values.
        rd(OFF_STATUS_A, 32'h0);
        rd(OFF_STATUS_B, 32'h0);
        rd(OFF_STATUS_WORD, 32'h700000f0);
        $display("reset test done");
        // Live status bits with every unit at level 0; writes must not stick.
        dma_end_req <= 4'ha;
        infrared_req <= 4'h5;
        fifo_serial_req <= 4'h9;
        conversion_end_req <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rd(OFF_STATUS_A, 32'h5a);
        rd(OFF_STATUS_B, 32'h19);
        wr(OFF_STATUS_A, 32'hff);
        wr(OFF_STATUS_B, 32'h1f);
        rd(OFF_STATUS_A, 32'h5a);
        rd(OFF_STATUS_B, 32'h19);
        dma_end_req <= 4'h0;
        infrared_req <= 4'h0;
        fifo_serial_req <= 4'h0;
        conversion_end_req <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rd(OFF_STATUS_A, 32'h0);
        $display("status test done");
        // Levels dma 3, infrared 5, fifo 5, converter 2; mask 4; infrared rx must win the tie.
        wr(OFF_PRIORITY, 32'h2553);
        wr(OFF_VECTOR_BASE, 32'h1000);
        wr(OFF_STATUS_WORD, 32'h40);
        dma_end_req <= 4'h1;
        infrared_req <= 4'h2;
        fifo_serial_req <= 4'h2;
        wait_take(32'h1600);
        chk({31'h0, request_out_pin_n}, 32'h0);
        rd(OFF_EVENT_CODE, 32'h4a0);
        rd(OFF_EVENT_CODE_ALT, 32'h4a0);
        rd(OFF_SAVED_STATUS, 32'h40);
        rd(OFF_SAVED_PC, 32'h2468);
        rd(OFF_STATUS_WORD, 32'h70000040);
        $display("take test done");
        // Pin follows the mask while the hold flag stays set.
        wr(OFF_STATUS_WORD, 32'h70000050);
        repeat (3) @(posedge ref_clk);
        chk({31'h0, request_out_pin_n}, 32'h1);
        wr(OFF_STATUS_WORD, 32'h70000040);
        repeat (3) @(posedge ref_clk);
        chk({31'h0, request_out_pin_n}, 32'h0);
        chk({24'h0, takes}, 32'h1);
        $display("pin test done");
        // Event interrupt: raise, mask, clear.
        rd(OFF_EVT_STATUS, 32'h3);
        wr(OFF_EVT_ENABLE, 32'h1);
        chk({31'h0, irq}, 32'h1);
        wr(OFF_EVT_ENABLE, 32'h0);
        chk({31'h0, irq}, 32'h0);
        wr(OFF_EVT_ENABLE, 32'h3);
        wr(OFF_EVT_CLEAR, 32'h3);
        chk({31'h0, irq}, 32'h0);
        rd(OFF_EVT_STATUS, 32'h0);
        rd(4'hf, 32'h0);
        $display("event test done");
        // Handler clears the source, reads back, waits, then opens nesting at its own level.
        dma_end_req <= 4'h0;
        infrared_req <= 4'h0;
        fifo_serial_req <= 4'h0;
        // The flag follows its line one edge late, so the read-back waits for that edge.
        @(posedge ref_clk);
        rd(OFF_STATUS_A, 32'h0);
        repeat (4) @(posedge ref_clk);
        wr(OFF_STATUS_WORD, 32'h50);
        slow <= 1'b1;
        fifo_serial_req <= 4'h8;
        conversion_end_req <= 1'b1;
        repeat (8) @(posedge ref_clk);
        chk({24'h0, takes}, 32'h1);
        wr(OFF_PRIORITY, 32'h7553);
        wait_take(32'h1600);
        rd(OFF_EVENT_CODE, 32'h580);
        rd(OFF_SAVED_PC, 32'h1600);
        rd(OFF_STATUS_WORD, 32'h70000050);
        $display("nesting test done");
        results();
    end
endmodule
